// file: rtl/vgc_pkg.sv
// Purpose: shared constants and types for the vbus guard and charger detect
// Assumes: 100 MHz clock, plain register port
// Notes: timing constants in their printed units, cycles derived
package vgc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_US = CLK_MHZ;
  localparam int ENGAGE_MIN_US = 500;
  localparam int ENGAGE_MAX_US = 1700;
  localparam int RELEASE_MIN_US = 3000;
  localparam int RELEASE_MAX_US = 6500;
  localparam int ALERT_US = 1000;
  localparam int DCD_MIN_MS = 40;
  localparam int DCD_MAX_MS = 150;
  localparam int STEP_MS = 80;
  // engage aims at 1.1 ms, inside 0.5 to 1.7 ms
  localparam int ENGAGE_CYC = (ENGAGE_MIN_US + ENGAGE_MAX_US) / 2 * CYC_PER_US;
  localparam int RELEASE_CYC = (RELEASE_MIN_US + RELEASE_MAX_US) / 2
                               * CYC_PER_US;
  localparam int ALERT_CYC = ALERT_US * CYC_PER_US;
  localparam int DCD_CYC = (DCD_MIN_MS + DCD_MAX_MS) / 2 * 1000 * CYC_PER_US;
  localparam int STEP_CYC = STEP_MS * 1000 * CYC_PER_US;

  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h1;
  localparam logic [3:0] REG_DETCFG = 4'h2;
  localparam logic [7:0] READ_UNMAPPED = 8'hff;

  // config bits
  localparam int CFG_SW_EN = 0;
  localparam int CFG_SW_MANUAL_OPEN = 1;
  localparam int CFG_OVERRIDE = 2;
  localparam int CFG_MUX_A = 3;
  localparam int CFG_MUX_B = 4;
  localparam logic [7:0] CONFIG_RESET = 8'h08;
  // detection config bits
  localparam int DET_CDP_EN = 0;
  localparam int DET_SE1_EN = 1;
  localparam logic [7:0] DETCFG_RESET = 8'h00;

  localparam logic [2:0] CLS_NONE = 3'h0;
  localparam logic [2:0] CLS_DCP = 3'h1;
  localparam logic [2:0] CLS_CDP = 3'h2;
  localparam logic [2:0] CLS_SDP = 3'h3;
  localparam logic [2:0] CLS_SE1_LOW = 3'h4;
  localparam logic [2:0] CLS_SE1_HIGH = 3'h5;
  localparam logic [1:0] LINE_SE0 = 2'h0;

  // analog comparator results from the DP/DM front end
  typedef struct packed {
    logic contact;     // data contact seen
    logic shorted;     // DP and DM shorted
    logic reflected;   // DP voltage seen on DM
    logic pulldowns;   // both lines pulled down
    logic dpSe1;       // DP near 2.0 V
    logic dmSe1Low;    // DM near 2.0 V
    logic dmSe1High;   // DM near 2.7 V
    logic [1:0] lineLevel;
    logic dataVolt;    // raw data voltage comparator
  } vgc_line_t;

  typedef struct packed {
    logic dataSource;
    logic sinkEnable;
    logic pullupSource;
  } vgc_drive_t;
endpackage : vgc_pkg

// file: rtl/vgc_sync.sv
// Purpose: two-flop synchroniser, one per bit
// Assumes: sync reset active low
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module vgc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : vgc_sync
`default_nettype wire

// file: rtl/vgc_timer.sv
// Purpose: down counter that flags when a started interval runs out
// Assumes: start and stop are one-cycle requests
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module vgc_timer #(
  parameter int WIDTH = 24
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic [WIDTH-1:0] load,
  output logic running,
  output logic done
);
  logic [WIDTH-1:0] count;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= load;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (count <= 1) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule : vgc_timer
`default_nettype wire

// file: rtl/vbus_guard_charger_detect.sv
// Purpose: vbus protection switch control and automatic charger detection
// Assumes: comparator inputs are asynchronous, registers on a plain port
// Notes: undervoltage drop acts as the block's register reset too
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - switch opens while vbus under or over the lockout window
// - software may force the switch open and set its configuration by writes
// - dead-battery variant, sdp found: current limit stays until software sets both switch enable and override
// - dead-battery variant, other chargers: limit on during detection, off after it
// - dead-battery variant keeps data source voltage on DP while the sdp current limit holds
// - detection starts on its own once vbus rises past undervoltage
// - detected class written to status bits 7:5 at completion
// - shorted lines report dedicated charging port, code 001
// - DP reflected on DM reports code 010, only if cdp enable set
// - pull-downs on both lines report standard port, code 011
// - both lines near 2.0 V report code 100, only if se1 enabled
// - DP 2.0 V and DM 2.7 V report code 101, only if se1 enabled
// - alert output pulled low when detection completes
// - data voltage detect asserts only when line level is 00
// - both mux paths forced off during automatic detection
// - switch opens 0.5 to 1.7 ms after vbus leaves window
// - switch closes 3 to 6.5 ms after vbus returns to window
// - alert releases after about 1 ms or on status read
// - contact step times out after 40 to 150 ms, then continues
module vbus_guard_charger_detect
  import vgc_pkg::*;
#(
  parameter int ENGAGE_CYCLES = ENGAGE_CYC,
  parameter int RELEASE_CYCLES = RELEASE_CYC,
  parameter int ALERT_CYCLES = ALERT_CYC,
  parameter int DCD_CYCLES = DCD_CYC,
  parameter int STEP_CYCLES = STEP_CYC,
  parameter bit DEAD_BATTERY = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic underVoltage,
  input wire logic overVoltage,
  input wire vgc_line_t lineIn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic switchClosed,
  output logic currentLimit,
  output logic muxPathA,
  output logic muxPathB,
  output vgc_drive_t lineDrive,
  output logic alert_n,
  output logic alertOe
);
  localparam int TW = 24;
  localparam int LW = $bits(vgc_line_t);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_DCD = 7'b000_0010,
    ST_PRIMARY = 7'b000_0100,
    ST_SECONDARY = 7'b000_1000,
    ST_SE1 = 7'b001_0000,
    ST_DONE = 7'b010_0000,
    ST_READY = 7'b100_0000
  } vgc_state_t;

  logic [1:0] vbusSync;
  vgc_line_t line;
  vgc_sync #(.WIDTH(2)) uVbus (
    .clock(clock), .rst_n(rst_n),
    .din({underVoltage, overVoltage}), .dout(vbusSync)
  );
  vgc_sync #(.WIDTH(LW)) uLine (
    .clock(clock), .rst_n(rst_n), .din(lineIn), .dout(line)
  );

  logic under;
  logic outside;
  assign under = vbusSync[1];
  assign outside = vbusSync[1] | vbusSync[0];
  // block held while vbus is below undervoltage, except lockout, switch and synchroniser flops
  logic live_n;
  assign live_n = rst_n & ~under;

  // lockout with engage and release delays
  logic lockout;
  logic [TW-1:0] vloCount;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lockout <= 1'b1;
      vloCount <= '0;
    end else if (lockout == outside) begin
      vloCount <= '0;
    end else if (lockout) begin
      if (vloCount >= TW'(RELEASE_CYCLES - 1)) begin
        lockout <= 1'b0;
        vloCount <= '0;
      end else begin
        vloCount <= vloCount + 1'b1;
      end
    end else begin
      if (vloCount >= TW'(ENGAGE_CYCLES - 1)) begin
        lockout <= 1'b1;
        vloCount <= '0;
      end else begin
        vloCount <= vloCount + 1'b1;
      end
    end
  end

  // registers
  logic [7:0] cfgReg;
  logic [7:0] detCfg;
  logic [2:0] chargerClass;
  vgc_state_t state;
  logic statusRead;
  assign statusRead = regRead && regAddr == REG_STATUS;

  always_ff @(posedge clock) begin
    if (!live_n) begin
      cfgReg <= CONFIG_RESET;
      detCfg <= DETCFG_RESET;
    end else if (regWrite) begin
      unique case (regAddr)
        REG_CONFIG: cfgReg <= regWdata;
        REG_DETCFG: detCfg <= regWdata;
        default: ;
      endcase
    end
  end

  logic dataVoltDetect;
  assign dataVoltDetect = line.dataVolt &&
                          line.lineLevel == LINE_SE0;

  // detection sequencer
  logic tStart;
  logic tStop;
  logic [TW-1:0] tLoad;
  logic tDone;
  vgc_timer #(.WIDTH(TW)) uStep (
    .clock(clock), .rst_n(live_n), .start(tStart), .stop(tStop),
    .load(tLoad), .running(), .done(tDone)
  );

  logic started;
  vgc_state_t next_state;
  logic [2:0] next_class;
  always_comb begin
    next_state = state;
    next_class = chargerClass;
    tStart = 1'b0;
    tStop = 1'b0;
    tLoad = TW'(STEP_CYCLES);
    unique case (state)
      ST_IDLE: begin
        if (!started) begin
          next_state = ST_DCD;
          tStart = 1'b1;
          tLoad = TW'(DCD_CYCLES);
        end
      end
      ST_DCD: begin
        if (line.contact || tDone) begin
          next_state = ST_PRIMARY;
          tStop = line.contact;
          tStart = 1'b1;
        end
      end
      ST_PRIMARY: begin
        if (tDone) begin
          tStart = 1'b1;
          if (dataVoltDetect || line.shorted) begin
            next_state = ST_SECONDARY;
          end else begin
            next_state = ST_SE1;
          end
        end
      end
      ST_SECONDARY: begin
        if (tDone) begin
          next_state = ST_DONE;
          if (line.shorted) begin
            next_class = CLS_DCP;
          end else if (line.reflected && detCfg[DET_CDP_EN]) begin
            next_class = CLS_CDP;
          end else begin
            next_class = CLS_NONE;
          end
        end
      end
      ST_SE1: begin
        if (tDone) begin
          next_state = ST_DONE;
          if (detCfg[DET_SE1_EN] && line.dpSe1 && line.dmSe1High) begin
            next_class = CLS_SE1_HIGH;
          end else if (detCfg[DET_SE1_EN] && line.dpSe1 && line.dmSe1Low) begin
            next_class = CLS_SE1_LOW;
          end else if (line.pulldowns) begin
            next_class = CLS_SDP;
          end else begin
            next_class = CLS_NONE;
          end
        end
      end
      ST_DONE: next_state = ST_READY;
      ST_READY: ;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!live_n) begin
      state <= ST_IDLE;
      started <= 1'b0;
      chargerClass <= CLS_NONE;
    end else begin
      state <= next_state;
      chargerClass <= next_class;
      if (state == ST_IDLE) begin
        started <= 1'b1;
      end
    end
  end

  logic detecting;
  // idle counts too, so no mux path opens in the cycle after power-up
  assign detecting = state != ST_READY;

  // alert: low at completion, self-release or status read
  logic [TW-1:0] alertCount;
  always_ff @(posedge clock) begin
    if (!live_n) begin
      alert_n <= 1'b1;
      alertOe <= 1'b0;
      alertCount <= '0;
    end else if (state == ST_DONE) begin
      alert_n <= 1'b0;
      alertOe <= 1'b1;
      alertCount <= TW'(ALERT_CYCLES - 1);
    end else if (alertOe && (statusRead || alertCount == '0)) begin
      alert_n <= 1'b1;
      alertOe <= 1'b0;
    end else if (alertOe) begin
      alertCount <= alertCount - 1'b1;
    end
  end

  // switch, limit and mux outputs
  logic sdpHold;
  assign sdpHold = chargerClass == CLS_SDP && !(cfgReg[CFG_SW_EN] &&
                   cfgReg[CFG_OVERRIDE]);

  // switch obeys lockout timing and the manual open bit; a dip shorter than the engage time
  // must not open it, so the undervoltage hold does not reach this flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      switchClosed <= 1'b0;
    end else begin
      // software can only open the switch, never defeat lockout
      switchClosed <= !lockout &&
                      !cfgReg[CFG_SW_MANUAL_OPEN];
    end
  end

  always_ff @(posedge clock) begin
    if (!live_n) begin
      currentLimit <= 1'b0;
    end else begin
      currentLimit <= DEAD_BATTERY &&
                      (detecting || sdpHold);
    end
  end

  always_ff @(posedge clock) begin
    if (!live_n) begin
      muxPathA <= 1'b0;
      muxPathB <= 1'b0;
    end else begin
      muxPathA <= cfgReg[CFG_MUX_A] && !detecting && !lockout;
      muxPathB <= cfgReg[CFG_MUX_B] && !detecting && !lockout;
    end
  end

  always_ff @(posedge clock) begin
    if (!live_n) begin
      lineDrive <= '0;
    end else begin
      lineDrive.pullupSource <= state == ST_DCD;
      lineDrive.dataSource <= state == ST_PRIMARY ||
                              (DEAD_BATTERY && sdpHold && state == ST_READY);
      lineDrive.sinkEnable <= state == ST_PRIMARY;
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge clock) begin
    if (!live_n) begin
      regRdata <= '0;
    end else if (regRead) begin
      unique case (regAddr)
        REG_STATUS: regRdata <= {chargerClass, 1'b0, currentLimit,
                                 !switchClosed, 1'b0, !vbusSync[0]};
        REG_CONFIG: regRdata <= cfgReg;
        REG_DETCFG: regRdata <= detCfg;
        default: regRdata <= READ_UNMAPPED;
      endcase
    end else begin
      regRdata <= '0;
    end
  end
endmodule : vbus_guard_charger_detect
`default_nettype wire

// file: tb/vgc_assertions.sv
// Purpose: port checks for vbus guard and charger detect
// Assumes: sim-sized counts handed on by the bind
// Notes: 8-cycle margins cover synchroniser lag
`timescale 1ns/1ps
`default_nettype none
module vgc_assertions
  import vgc_pkg::*;
#(
  parameter int ENGAGE_CYCLES = 20,
  parameter int RELEASE_CYCLES = 40,
  parameter int ALERT_CYCLES = 30
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic underVoltage,
  input wire logic overVoltage,
  input wire logic [3:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic switchClosed,
  input wire logic currentLimit,
  input wire logic muxPathA,
  input wire logic muxPathB,
  input wire logic alert_n,
  input wire logic alertOe
);
  localparam int ALERT_MAX = ALERT_CYCLES + 8;
  int outCnt;
  int inCnt;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outCnt <= 0;
      inCnt <= 0;
    end else begin
      outCnt <= (underVoltage || overVoltage) ? outCnt + 1 : 0;
      inCnt <= (underVoltage || overVoltage) ? 0 : inCnt + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_alert_fall;
    $fell(alert_n);
  endsequence
  a_lockout_opens: assert property (
    outCnt > ENGAGE_CYCLES + 8 |-> !switchClosed && !muxPathA && !muxPathB)
    else $error("switch or mux on during long lockout");
  // manual writes excluded, they may open the switch early
  a_engage_early: assert property (
    switchClosed && !underVoltage && !regWrite && !$past(regWrite)
    && !$past(regWrite, 2) && outCnt < ENGAGE_CYCLES / 2 |=> switchClosed)
    else $error("switch opened too soon");
  a_release_early: assert property (
    !switchClosed && inCnt > 0 && inCnt < RELEASE_CYCLES / 2
    |=> !switchClosed) else $error("switch closed too soon");
  a_alert_release: assert property (
    s_alert_fall |-> ##[1:ALERT_MAX] alert_n)
    else $error("alert held too long");
  a_alert_drive: assert property (
    alertOe == !alert_n) else $error("alert enable disagrees with level");
  a_status_clear: assert property (
    !alert_n && regRead && regAddr == REG_STATUS |-> ##[1:3] alert_n)
    else $error("status read kept alert low");
  a_status_bits: assert property (
    regRead && regAddr == REG_STATUS |=> regRdata[3:2] ==
    {$past(currentLimit), !$past(switchClosed)})
    else $error("status bits disagree with outputs");
  a_unmapped_read: assert property (
    regRead && regAddr > REG_DETCFG |=> regRdata == READ_UNMAPPED)
    else $error("unmapped read not all ones");
  a_rdata_idle: assert property (
    !regRead |=> regRdata == 8'h00) else $error("read data outside slot");
endmodule : vgc_assertions
bind vbus_guard_charger_detect vgc_assertions #(
  .ENGAGE_CYCLES(ENGAGE_CYCLES),
  .RELEASE_CYCLES(RELEASE_CYCLES),
  .ALERT_CYCLES(ALERT_CYCLES)
) u_vgc_chk (
  .clock, .rst_n, .underVoltage, .overVoltage, .regAddr, .regWrite,
  .regRead, .regRdata, .switchClosed, .currentLimit, .muxPathA,
  .muxPathB, .alert_n, .alertOe
);
`default_nettype wire

// file: tb/vgc_charger.sv
// Purpose: charger or host port model on the data lines
// Assumes: kind 0 open port, others follow the class codes
// Notes: contact shows late so detection config can land first
`timescale 1ns/1ps
`default_nettype none
module vgc_charger
  import vgc_pkg::*;
(
  input wire logic clock,
  input wire logic present,
  input wire logic [2:0] kind,
  input wire vgc_drive_t drive,
  output vgc_line_t line
);
  logic [3:0] age;
  always_ff @(posedge clock) begin
    if (!present) begin
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  // unplugged lines sit at the device pull-downs
  always_comb begin
    line = '0;
    if (present) begin
      line.contact = (kind != CLS_NONE) && (age > 4'h9);
      case (kind)
        CLS_DCP: begin
          line.shorted = 1'b1;
          line.dataVolt = drive.dataSource;
        end
        CLS_CDP: begin
          line.reflected = 1'b1;
          line.dataVolt = drive.dataSource;
        end
        CLS_SDP: line.pulldowns = 1'b1;
        default: begin
          line.dpSe1 = kind[2];
          line.dmSe1Low = (kind == CLS_SE1_LOW);
          line.dmSe1High = (kind == CLS_SE1_HIGH);
          line.lineLevel = {2{kind[2]}};
          line.dataVolt = kind[2];  // raw high, yet level not 00
        end
      endcase
    end
  end
endmodule : vgc_charger
`default_nettype wire

// file: tb/vbus_guard_charger_detect_tb_top.sv
// Purpose: self-checking bench for vbus guard and charger detect
// Assumes: shortened counts, charger model on the line inputs
// Notes: outputs sampled on falling edges to stay clear of races
`timescale 1ns/1ps
`default_nettype none
module vbus_guard_charger_detect_tb_top
  import vgc_pkg::*;
();
  localparam int ENG = 20;
  localparam int REL = 40;
  localparam int ALR = 30;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic underVoltage = 1'b1;
  logic overVoltage = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [2:0] kind = 3'h0;
  vgc_line_t lineIn;
  vgc_drive_t lineDrive;
  logic [7:0] regRdata, d, o;
  logic switchClosed, currentLimit, muxPathA, muxPathB, alert_n, alertOe;
  int nFail = 0;
  int nChecks = 0;
  always #5 clock = ~clock;
  vbus_guard_charger_detect #(
    .ENGAGE_CYCLES(ENG), .RELEASE_CYCLES(REL), .ALERT_CYCLES(ALR),
    .DCD_CYCLES(50), .STEP_CYCLES(20), .DEAD_BATTERY(1'b1)
  ) DUT (
    .clock, .rst_n, .underVoltage, .overVoltage, .lineIn, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .switchClosed,
    .currentLimit, .muxPathA, .muxPathB, .lineDrive, .alert_n, .alertOe
  );
  vgc_charger u_chg (
    .clock, .present(!underVoltage), .kind, .drive(lineDrive), .line(lineIn)
  );
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  // data stands one cycle only, so it is caught mid-cycle
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdata;
    @(posedge clock);
  endtask : rd
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
    o = {alert_n, switchClosed, currentLimit, muxPathA, muxPathB, lineDrive};
    @(posedge clock);
  endtask : pause
  task automatic run(input logic [2:0] k, input logic [7:0] det,
                     input logic [2:0] cls, input logic lim, input bit hold);
    int t;
    t = 0;
    underVoltage <= 1'b1;
    repeat (6) @(posedge clock);
    underVoltage <= 1'b0;
    kind <= k;
    repeat (5) @(posedge clock);
    wr(REG_DETCFG, det);
    rd(REG_CONFIG);
    check("config reset", CONFIG_RESET, d);
    pause(0);
    check("limit in detection", 8'h01, 8'(o[5]));
    check("contact source", 8'h01, 8'(o[0]));
    while (o[7] && t < 400) begin
      if (o[6]) check("mux gated", 8'h00, 8'(o[4:3]));
      pause(0);
      t++;
    end
    check("detection done", 8'h00, 8'(o[7]));
    if (hold) begin
      pause(ALR + 4);
      check("alert self clear", 8'h01, 8'(o[7]));
    end
    rd(REG_STATUS);
    check("class", 8'(cls), 8'(d[7:5]));
    pause(2);
    check("limit after", 8'(lim), 8'(o[5]));
    check("line drive", 8'({lim, 2'b00}), 8'(o[2:0]));
    check("alert cleared", 8'h01, 8'(o[7]));
    $display("test kind %0d done", k);
  endtask : run
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tallyAndFinish
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    run(CLS_DCP, 8'h00, CLS_DCP, 1'b0, 1'b0);
    run(CLS_CDP, 8'h01, CLS_CDP, 1'b0, 1'b0);
    run(CLS_CDP, 8'h00, CLS_NONE, 1'b0, 1'b0);
    run(CLS_SE1_LOW, 8'h02, CLS_SE1_LOW, 1'b0, 1'b0);
    run(CLS_SE1_HIGH, 8'h02, CLS_SE1_HIGH, 1'b0, 1'b0);
    run(CLS_SE1_LOW, 8'h00, CLS_NONE, 1'b0, 1'b0);
    run(CLS_NONE, 8'h03, CLS_NONE, 1'b0, 1'b1);
    run(CLS_SDP, 8'h00, CLS_SDP, 1'b1, 1'b0);
    wr(REG_CONFIG, 8'h05); // mux enables cleared
    pause(3);
    check("limit released", 8'h00, 8'(o[5]));
    check("switch enabled", 8'h01, 8'(o[6]));
    overVoltage <= 1'b1;
    repeat (ENG / 2 - 4) @(posedge clock);
    overVoltage <= 1'b0;
    pause(4);
    check("switch on bounce", 8'h01, 8'(o[6]));
    overVoltage <= 1'b1;
    pause(ENG + 10);
    check("switch locked", 8'h00, 8'(o[6]));
    rd(REG_STATUS);
    check("status lockout", 8'h02, 8'({d[2], d[0]}));
    overVoltage <= 1'b0;
    pause(REL / 2);
    check("switch held open", 8'h00, 8'(o[6]));
    pause(REL);
    check("switch reclosed", 8'h01, 8'(o[6]));
    wr(REG_CONFIG, 8'h07);
    pause(3);
    check("manual open", 8'h00, 8'(o[6]));
    rd(REG_CONFIG);
    check("config readback", 8'h07, d);
    wr(REG_STATUS, 8'hff);
    rd(4'hf);
    check("unmapped read", READ_UNMAPPED, d);
    rd(REG_STATUS);
    check("status kept", 8'(CLS_SDP), 8'(d[7:5]));
    $display("test lockout and registers done");
    tallyAndFinish();
  end
  initial begin
    repeat (8000) @(posedge clock);
    nFail++;
    $display("ERROR watchdog expected finish seen hang");
    tallyAndFinish();
  end
endmodule : vbus_guard_charger_detect_tb_top
`default_nettype wire
